/* File: rtl/dbf_fifo_mailbox.sv */
// two queues in opposite directions plus a mailbox per direction
// port clocks arrive as pins and are oversampled by clk, which must run
// well above twice the faster port clock
`timescale 1ns/1ps
module dbf_fifo_mailbox #(
    parameter int DATA_W = dbf_pkg::DATA_W,
    parameter int DEPTH = dbf_pkg::DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic dev_reset_n,
    input wire logic offset_select_lo,
    input wire logic offset_select_hi,
    input wire logic port_a_clock,
    input wire logic port_a_select_n,
    input wire logic port_a_write_not_read,
    input wire logic port_a_xfer_gate,
    input wire logic port_a_mail_select,
    input wire logic [DATA_W-1:0] port_a_data_in,
    output logic [DATA_W-1:0] port_a_data_out,
    output logic port_a_data_oe,
    input wire logic port_b_clock,
    input wire logic port_b_select_n,
    input wire logic port_b_write_not_read,
    input wire logic port_b_xfer_gate,
    input wire logic port_b_mail_select,
    input wire logic [DATA_W-1:0] port_b_data_in,
    output logic [DATA_W-1:0] port_b_data_out,
    output logic port_b_data_oe,
    output logic a_side_full_n,
    output logic a_side_almost_full_n,
    output logic a_side_empty_n,
    output logic a_side_almost_empty_n,
    output logic b_side_full_n,
    output logic b_side_almost_full_n,
    output logic b_side_empty_n,
    output logic b_side_almost_empty_n,
    output logic a_to_b_mail_flag_n,
    output logic b_to_a_mail_flag_n
);
    localparam int PTR_W = $clog2(DEPTH) + 1; // one spare bit for full
    localparam logic [PTR_W-1:0] FULL_CNT = PTR_W'(DEPTH);

    // the offset field must fit below half the depth, and the pin
    // carrier is sized by the package width, not by this parameter
    if (DEPTH < 64 || (DEPTH & (DEPTH - 1)) != 0
        || DATA_W != dbf_pkg::DATA_W)
    begin : g_bad_param
        $error("DEPTH or DATA_W not supported");
    end

    // index 0 is port a / a_to_b queue, index 1 is port b / b_to_a queue
    dbf_pkg::dbf_pin_t pin_w [2]; // raw pins
    dbf_pkg::dbf_pin_t s1_q [2]; // first sync stage, read only by s2_q
    dbf_pkg::dbf_pin_t s2_q [2]; // usable samples
    logic clk_prev_q [2]; // previous sampled port clock
    logic edge_w [2]; // one clk pulse per port clock rise
    logic [2:0] rst_s1_q; // reset pin and offset selects, first stage
    logic [2:0] rst_s2_q; // same, second stage
    logic rst_prev_q; // previous synced reset level
    logic in_rst_w; // device reset pin held low
    logic rst_rise_w; // release of the device reset pin
    logic [5:0] ofs_q; // almost-flag offset
    logic sel_w [2]; // gated, selected port edge
    logic wr_w [2]; // queue write by port p into queue p
    logic rd_w [2]; // queue read by port p from queue 1-p
    logic mw_w [2]; // mailbox write by port p into mailbox p
    logic mr_w [2]; // mailbox read by port p of mailbox 1-p
    logic [PTR_W-1:0] wptr_q [2]; // write pointers
    logic [PTR_W-1:0] rptr_q [2]; // read pointers
    logic [PTR_W-1:0] cnt_w [2]; // fill level per queue
    logic [DATA_W-1:0] oreg_q [2]; // queue output registers
    logic [DATA_W-1:0] mbox_q [2]; // mailboxes
    logic mflag_q [2]; // new-mail flags, low means mail waiting
    logic [1:0] full1_q, full2_q, afull1_q, afull2_q; // writer side
    logic [1:0] emp1_q, emp2_q, aemp1_q, aemp2_q; // reader side
    logic [DATA_W-1:0] dout_q [2]; // driven data
    logic oe_q [2]; // data output enables

    assign pin_w[0] = '{port_a_clock, port_a_select_n,
                        port_a_write_not_read, port_a_xfer_gate,
                        port_a_mail_select, port_a_data_in};
    assign pin_w[1] = '{port_b_clock, port_b_select_n,
                        port_b_write_not_read, port_b_xfer_gate,
                        port_b_mail_select, port_b_data_in};

    // reset pin is asynchronous to everything, so it is synchronised
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rst_s1_q <= 3'h0;
            rst_s2_q <= 3'h0;
            rst_prev_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= {dev_reset_n, offset_select_hi,
                         offset_select_lo};
            rst_s2_q <= rst_s1_q;
            rst_prev_q <= rst_s2_q[2];
        end
    end

    assign in_rst_w = ~rst_s2_q[2];
    assign rst_rise_w = rst_s2_q[2] & ~rst_prev_q;

    // offset latched at the release of the device reset
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ofs_q <= dbf_pkg::OFS_LL;
        else if (rst_rise_w)
            ofs_q <= dbf_pkg::dbf_ofs(rst_s2_q[1:0]);
    end

    // per-port sampling, decoding, mailbox and output drive
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        // all pins of a port share one synchroniser, keeping them aligned
        always_ff @(posedge clk or posedge reset)
        begin
            if (reset)
            begin
                s1_q[p] <= '0;
                s2_q[p] <= '0;
                clk_prev_q[p] <= 1'b0;
            end
            else
            begin
                s1_q[p] <= pin_w[p];
                s2_q[p] <= s1_q[p];
                clk_prev_q[p] <= s2_q[p].clk;
            end
        end

        assign edge_w[p] = s2_q[p].clk & ~clk_prev_q[p];
        // nothing moves with the gate low, so select may glitch then
        assign sel_w[p] = edge_w[p] & ~s2_q[p].sel_n & s2_q[p].gate
                          & ~in_rst_w;
        // writes checked against the raw level too, so no overflow
        assign wr_w[p] = sel_w[p] & s2_q[p].wnr & ~s2_q[p].mail
                         & full2_q[p]
                         & (cnt_w[p] != FULL_CNT);
        assign rd_w[p] = sel_w[p] & ~s2_q[p].wnr & ~s2_q[p].mail
                         & emp2_q[1-p] & (cnt_w[1-p] != '0);
        assign mw_w[p] = sel_w[p] & s2_q[p].wnr & s2_q[p].mail
                         & mflag_q[p];
        assign mr_w[p] = sel_w[p] & ~s2_q[p].wnr & s2_q[p].mail;

        // mailbox keeps its word until the next accepted write
        always_ff @(posedge clk or posedge reset)
        begin
            if (reset)
                mbox_q[p] <= '0;
            else if (mw_w[p])
                mbox_q[p] <= s2_q[p].data;
        end

        // a write beats a same-cycle far read, so fresh mail is not lost
        always_ff @(posedge clk or posedge reset)
        begin
            if (reset)
                mflag_q[p] <= dbf_pkg::RST_MAIL_N;
            else if (in_rst_w)
                mflag_q[p] <= dbf_pkg::RST_MAIL_N;
            else if (mw_w[p])
                mflag_q[p] <= 1'b0;
            else if (mr_w[1-p])
                mflag_q[p] <= 1'b1;
        end

        // drive follows select and direction only, not the gate
        always_ff @(posedge clk or posedge reset)
        begin
            if (reset)
            begin
                oe_q[p] <= 1'b0;
                dout_q[p] <= '0;
            end
            else
            begin
                oe_q[p] <= ~s2_q[p].sel_n & ~s2_q[p].wnr;
                dout_q[p] <= s2_q[p].mail ? mbox_q[1-p]
                                          : oreg_q[1-p];
            end
        end
    end

    // queue q is written by port q and read by port 1-q
    for (genvar q = 0; q < 2; q++)
    begin : g_queue
        localparam int R = 1 - q; // reading port
        logic [DATA_W-1:0] mem [DEPTH];
        logic [PTR_W-1:0] lim_af_w; // almost-full threshold
        logic raw_full_n_w, raw_afull_n_w, raw_emp_n_w, raw_aemp_n_w;

        assign cnt_w[q] = wptr_q[q] - rptr_q[q];
        assign lim_af_w = FULL_CNT - PTR_W'(ofs_q);
        assign raw_full_n_w = cnt_w[q] != FULL_CNT;
        assign raw_afull_n_w = cnt_w[q] < lim_af_w;
        assign raw_emp_n_w = cnt_w[q] != '0;
        assign raw_aemp_n_w = cnt_w[q] > PTR_W'(ofs_q);

        // storage has no reset: pointers define what is valid
        always_ff @(posedge clk)
        begin
            if (wr_w[q])
                mem[wptr_q[q][PTR_W-2:0]] <= s2_q[q].data;
        end

        // pointers and the output register of this queue
        always_ff @(posedge clk or posedge reset)
        begin
            if (reset)
            begin
                wptr_q[q] <= '0;
                rptr_q[q] <= '0;
                oreg_q[q] <= '0;
            end
            else if (in_rst_w)
            begin
                wptr_q[q] <= '0;
                rptr_q[q] <= '0;
            end
            else
            begin
                if (wr_w[q])
                    wptr_q[q] <= wptr_q[q] + 1'b1;
                if (rd_w[R])
                begin
                    oreg_q[q] <= mem[rptr_q[q][PTR_W-2:0]];
                    rptr_q[q] <= rptr_q[q] + 1'b1;
                end
            end
        end

        // writer-clock flags: fall on the next writer edge, rise after two writer edges;
        // a change landing after an edge waits for the next one
        always_ff @(posedge clk or posedge reset)
        begin
            if (reset)
            begin
                {full1_q[q], full2_q[q]} <= {2{dbf_pkg::RST_FULL_N}};
                {afull1_q[q], afull2_q[q]} <= {2{dbf_pkg::RST_AFULL_N}};
            end
            else if (in_rst_w)
            begin
                {full1_q[q], full2_q[q]} <= {2{dbf_pkg::RST_FULL_N}};
                {afull1_q[q], afull2_q[q]} <= {2{dbf_pkg::RST_AFULL_N}};
            end
            else if (edge_w[q])
            begin
                full1_q[q] <= raw_full_n_w;
                full2_q[q] <= full1_q[q] & raw_full_n_w;
                afull1_q[q] <= raw_afull_n_w;
                afull2_q[q] <= afull1_q[q] & raw_afull_n_w;
            end
        end

        // reader-clock flags, same two-edge scheme on the reading port
        always_ff @(posedge clk or posedge reset)
        begin
            if (reset)
            begin
                {emp1_q[q], emp2_q[q]} <= {2{dbf_pkg::RST_EMPTY_N}};
                {aemp1_q[q], aemp2_q[q]} <= {2{dbf_pkg::RST_AEMPTY_N}};
            end
            else if (in_rst_w)
            begin
                {emp1_q[q], emp2_q[q]} <= {2{dbf_pkg::RST_EMPTY_N}};
                {aemp1_q[q], aemp2_q[q]} <= {2{dbf_pkg::RST_AEMPTY_N}};
            end
            else if (edge_w[R])
            begin
                emp1_q[q] <= raw_emp_n_w;
                emp2_q[q] <= emp1_q[q] & raw_emp_n_w;
                aemp1_q[q] <= raw_aemp_n_w;
                aemp2_q[q] <= aemp1_q[q] & raw_aemp_n_w;
            end
        end
    end

    // outputs straight from flops; each flag names its own queue
    assign port_a_data_out = dout_q[0];
    assign port_a_data_oe = oe_q[0];
    assign port_b_data_out = dout_q[1];
    assign port_b_data_oe = oe_q[1];
    assign a_side_full_n = full2_q[0];
    assign a_side_almost_full_n = afull2_q[0];
    assign a_side_empty_n = emp2_q[1];
    assign a_side_almost_empty_n = aemp2_q[1];
    assign b_side_full_n = full2_q[1];
    assign b_side_almost_full_n = afull2_q[1];
    assign b_side_empty_n = emp2_q[0];
    assign b_side_almost_empty_n = aemp2_q[0];
    assign a_to_b_mail_flag_n = mflag_q[0];
    assign b_to_a_mail_flag_n = mflag_q[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_mail_sent;
        mw_w[0] && !mr_w[1];
    endsequence

    chk_reset_flags_init: assert property (in_rst_w |=>
        full2_q == 2'h0 && emp2_q == 2'h0 && aemp2_q == 2'h0
        && afull2_q == 2'h3 && mflag_q[0] && mflag_q[1])
        else $error("flags wrong during device reset");
    chk_offset_load_value: assert property (rst_rise_w |=>
        ofs_q == dbf_pkg::dbf_ofs($past(rst_s2_q[1:0])))
        else $error("offset not loaded at reset release");
    chk_drive_read_only: assert property (oe_q[0] |->
        $past(!s2_q[0].sel_n && !s2_q[0].wnr))
        else $error("port a drives outside a read select");
    chk_full_blocks_write: assert property (!full2_q[0] |=>
        wptr_q[0] == $past(wptr_q[0]) || $past(in_rst_w))
        else $error("write taken while full flag low");
    chk_read_ptr_step: assert property (rd_w[0] |=>
        rptr_q[1] == $past(rptr_q[1]) + 1'b1)
        else $error("read pointer did not advance by one");
    chk_mail_write_lock: assert property (s_mail_sent |=>
        !mflag_q[0] && mbox_q[0] == $past(s2_q[0].data))
        else $error("mailbox write did not lock flag");
    chk_mail_contents_hold: assert property (!mw_w[1] |=>
        $stable(mbox_q[1]))
        else $error("mailbox changed without a write");
    chk_empty_two_edges: assert property ($rose(emp2_q[1]) |->
        $past(edge_w[0]) && $past(emp1_q[1]))
        else $error("empty flag rose without two reader edges");
    chk_empty_ignores_read: assert property (!emp2_q[0] |->
        !rd_w[1])
        else $error("read taken while empty flag low");

endmodule : dbf_fifo_mailbox

/* File: rtl/dbf_pkg.sv */
// constants, carriers and the offset decode for the two-way queue pair
// assumes a single fast system clock that oversamples both port clocks
// Behaviour
// - reset pin may change at any time
// - reset clears pointers, sets documented flag levels
// - full flag rises two writer edges after reset
// - reset release latches offset from select pins
// - data driven only while selected for read
// - port a writes a_to_b queue when allowed
// - port a reads b_to_a queue when allowed
// - port a write with mail stores mailbox
// - port a mail read releases b_to_a mailbox
// - port a shows queue or mailbox by select
// - port b mirrors port a decoding
// - port b writes b_to_a queue when allowed
// - low transfer gate means no transfer
// - status flags pass two port clock stages
// - each flag reports its documented queue
// - flag levels follow fill and offset
// - reads ignored while empty flag low
// - read pointer advances once per word
// - empty rises on second reader edge
// - late edges defer first sync cycle
// - writes ignored while full; full rises later
// - mailbox write locks until far read
// - mailbox keeps contents after being read
// - almost flags rise on second sync edge
package dbf_pkg;

    localparam int DATA_W = 36; // word width
    localparam int DEPTH = 64; // words per queue
    localparam int SYNC_EDGES = 2; // flag synchroniser depth

    // offset register choices
    localparam logic [5:0] OFS_HH = 6'h10;
    localparam logic [5:0] OFS_HL = 6'h0C;
    localparam logic [5:0] OFS_LH = 6'h08;
    localparam logic [5:0] OFS_LL = 6'h04;

    // flag levels while the device reset pin is low
    localparam logic RST_FULL_N = 1'b0;
    localparam logic RST_EMPTY_N = 1'b0;
    localparam logic RST_AEMPTY_N = 1'b0;
    localparam logic RST_AFULL_N = 1'b1;
    localparam logic RST_MAIL_N = 1'b1;

    // one port's pins, sampled together so they stay aligned
    typedef struct packed {
        logic clk;
        logic sel_n;
        logic wnr;
        logic gate;
        logic mail;
        logic [DATA_W-1:0] data;
    } dbf_pin_t;

    // offset select pins to offset value
    function automatic logic [5:0] dbf_ofs(input logic [1:0] fs);
        logic [5:0] v;
        v = OFS_LL;
        unique case (fs)
            2'h3: v = OFS_HH;
            2'h2: v = OFS_HL;
            2'h1: v = OFS_LH;
            2'h0: v = OFS_LL;
        endcase
        return v;
    endfunction : dbf_ofs

endpackage : dbf_pkg

/* File: tb/dbf_port_host.sv */
// behavioural host for one port: makes the port clock and runs transfers
// assumes the block oversamples these pins with clk, well above port rate
`timescale 1ns/1ps
module dbf_port_host #(
    parameter int HALF = 4 // clk cycles per port clock half period
) (
    input wire logic clk,
    output logic port_clock,
    output logic select_n,
    output logic write_not_read,
    output logic xfer_gate,
    output logic mail_select,
    output logic [dbf_pkg::DATA_W-1:0] data_in,
    input wire logic [dbf_pkg::DATA_W-1:0] data_out
);
    int cnt = 0; // clk cycles into this half period

    // idle host: deselected, no transfer
    initial
    begin
        port_clock = 1'b0;
        select_n = 1'b1;
        write_not_read = 1'b0;
        xfer_gate = 1'b0;
        mail_select = 1'b0;
        data_in = '0;
    end

    // free-running port clock, moved on falling clk edges only
    always @(negedge clk)
    begin
        if (cnt == HALF - 1)
        begin
            cnt <= 0;
            port_clock <= ~port_clock;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end

    // one port cycle: pins change at the port fall, held over the rise,
    // then the gate drops so a standing request is not taken again
    task automatic op(input logic sn, input logic wnr, input logic gate,
                      input logic mail, input logic [dbf_pkg::DATA_W-1:0] d);
        @(negedge port_clock);
        select_n = sn;
        write_not_read = wnr;
        xfer_gate = gate;
        mail_select = mail;
        // a released data line must not keep showing the last word
        data_in = (sn == 1'b0 && wnr == 1'b1) ? d : ~data_in;
        @(posedge port_clock);
        @(negedge port_clock);
        xfer_gate = 1'b0;
    endtask : op

    // read, then one gated-off cycle so the answer has settled
    task automatic rd(input logic mail,
                      output logic [dbf_pkg::DATA_W-1:0] v);
        op(1'b0, 1'b0, 1'b1, mail, '0);
        op(1'b0, 1'b0, 1'b0, mail, '0);
        v = data_out;
    endtask : rd
endmodule : dbf_port_host

/* File: tb/test_dbf_fifo_mailbox.sv */
// self-checking bench for the two-way queue pair and its mailboxes
// assumes two host models on the ports and one 125 MHz system clock
`timescale 1ns/1ps
module test_dbf_fifo_mailbox;
    localparam int W = dbf_pkg::DATA_W;
    logic clk = 1'b0; // system clock
    logic reset = 1'b1; // system reset
    logic dev_reset_n = 1'b0; // device reset pin
    logic fs_lo = 1'b0;
    logic fs_hi = 1'b0;
    logic a_clk, a_sel_n, a_wnr, a_gate, a_mail, a_oe;
    logic b_clk, b_sel_n, b_wnr, b_gate, b_mail, b_oe;
    logic [W-1:0] a_din, a_dout, b_din, b_dout, v;
    logic a_full_n, a_afull_n, a_empty_n, a_aempty_n;
    logic b_full_n, b_afull_n, b_empty_n, b_aempty_n;
    logic a2b_mail_n, b2a_mail_n;
    int num_errors = 0;
    int checked = 0;
    int cnt;
    int b_rises = 0; // port b clock rises so far
    int a_mark = 0; // b_rises at the latest port a clock rise
    // rows: offset select pins beside the offset they should load
    logic [1:0] row_fs [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    int row_x [4] = '{16, 12, 8, 4};

    always #4 clk = ~clk;

    // reader edges counted from the writing edge, for the latency test
    always @(posedge b_clk)
        b_rises++;
    always @(posedge a_clk)
        a_mark = b_rises;

    dbf_fifo_mailbox i_dbf_fifo_mailbox (.clk(clk), .reset(reset),
        .dev_reset_n(dev_reset_n), .offset_select_lo(fs_lo),
        .offset_select_hi(fs_hi), .port_a_clock(a_clk),
        .port_a_select_n(a_sel_n), .port_a_write_not_read(a_wnr),
        .port_a_xfer_gate(a_gate), .port_a_mail_select(a_mail),
        .port_a_data_in(a_din), .port_a_data_out(a_dout),
        .port_a_data_oe(a_oe), .port_b_clock(b_clk),
        .port_b_select_n(b_sel_n), .port_b_write_not_read(b_wnr),
        .port_b_xfer_gate(b_gate), .port_b_mail_select(b_mail),
        .port_b_data_in(b_din), .port_b_data_out(b_dout),
        .port_b_data_oe(b_oe), .a_side_full_n(a_full_n),
        .a_side_almost_full_n(a_afull_n), .a_side_empty_n(a_empty_n),
        .a_side_almost_empty_n(a_aempty_n), .b_side_full_n(b_full_n),
        .b_side_almost_full_n(b_afull_n), .b_side_empty_n(b_empty_n),
        .b_side_almost_empty_n(b_aempty_n),
        .a_to_b_mail_flag_n(a2b_mail_n), .b_to_a_mail_flag_n(b2a_mail_n));

    // unequal port rates keep the two ports out of step
    dbf_port_host #(.HALF(4)) i_host_a (.clk(clk), .port_clock(a_clk),
        .select_n(a_sel_n), .write_not_read(a_wnr), .xfer_gate(a_gate),
        .mail_select(a_mail), .data_in(a_din), .data_out(a_dout));
    dbf_port_host #(.HALF(5)) i_host_b (.clk(clk), .port_clock(b_clk),
        .select_n(b_sel_n), .write_not_read(b_wnr), .xfer_gate(b_gate),
        .mail_select(b_mail), .data_in(b_din), .data_out(b_dout));

    // compare one value, count it, report a mismatch at once
    task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    // enough time for several edges of both port clocks
    task automatic settle();
        repeat (40) @(negedge clk);
    endtask : settle

    // device reset with the given offset pins, flags checked on the way
    task automatic dev_reset(input logic [1:0] fs);
        @(negedge clk);
        dev_reset_n = 1'b0;
        fs_hi = fs[1];
        fs_lo = fs[0];
        repeat (60) @(negedge clk);
        check({a_full_n, a_empty_n, a_aempty_n, a_afull_n,
               b_full_n, b_empty_n, b_aempty_n, b_afull_n,
               a2b_mail_n, b2a_mail_n}, W'(10'h047));
        dev_reset_n = 1'b1;
        repeat (4) @(negedge clk);
        check(a_full_n, 0);
        repeat (56) @(negedge clk);
        check({a_full_n, b_full_n}, 2'h3);
    endtask : dev_reset

    // read port b queue and compare
    task automatic rd_b(input logic [W-1:0] exp);
        i_host_b.rd(1'b0, v);
        check(v, exp);
    endtask : rd_b

    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // watchdog: the whole run needs well under 100 us
    initial
    begin
        #200us;
        num_errors++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        // offsets: fill to X then X+1 words, watch almost-empty
        for (int r = 0; r < 4; r++)
        begin
            dev_reset(row_fs[r]);
            for (int i = 0; i < row_x[r]; i++)
                i_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, W'(i));
            settle();
            check(b_aempty_n, 0);
            check(b_empty_n, 1);
            i_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, W'(row_x[r]));
            settle();
            check(b_aempty_n, 1);
        end
        // offset is now 4 and five words wait; fill to the top
        for (int i = 5; i < 64; i++)
        begin
            i_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, W'(i));
            if (i == 58 || i == 59 || i == 62)
            begin
                settle();
                check(a_afull_n, W'(i == 58));
                check(a_full_n, 1);
            end
        end
        settle();
        check(a_full_n, 0);
        i_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, W'(99)); // dropped: full
        rd_b(0);
        settle();
        check(a_full_n, 1);
        for (int i = 1; i < 64; i++)
            rd_b(W'(i));
        settle();
        check(b_empty_n, 0);
        rd_b(63);
        // gate low: nothing moves
        i_host_a.op(1'b0, 1'b1, 1'b0, 1'b0, W'(8));
        settle();
        check(b_empty_n, 0);
        // first word into an empty queue: count reader edges
        i_host_a.op(1'b0, 1'b1, 1'b1, 1'b0, W'(7));
        cnt = a_mark;
        while (b_empty_n !== 1'b1 && b_rises - cnt < 8)
            @(negedge clk);
        cnt = b_rises - cnt;
        check(W'(cnt == 2 || cnt == 3), 1);
        rd_b(7);
        check(b_oe, 1);
        i_host_b.op(1'b1, 1'b0, 1'b0, 1'b0, '0);
        i_host_b.op(1'b0, 1'b1, 1'b0, 1'b0, '0);
        check(b_oe, 0);
        // port b to port a queue
        for (int i = 0; i < 3; i++)
            i_host_b.op(1'b0, 1'b1, 1'b1, 1'b0, W'(16 + i));
        settle();
        check(a_empty_n, 1);
        for (int i = 0; i < 3; i++)
        begin
            i_host_a.rd(1'b0, v);
            check(v, W'(16 + i));
        end
        check(a_oe, 1);
        // a to b mailbox: second write locked out until b reads
        i_host_a.op(1'b0, 1'b1, 1'b1, 1'b1, W'(21));
        settle();
        check(a2b_mail_n, 0);
        check(a_oe, 0);
        i_host_a.op(1'b0, 1'b1, 1'b1, 1'b1, W'(22));
        i_host_b.rd(1'b1, v);
        check(v, W'(21));
        settle();
        check(a2b_mail_n, 1);
        i_host_b.rd(1'b1, v);
        check(v, W'(21));
        // b to a mailbox, then the queue register shows again
        i_host_b.op(1'b0, 1'b1, 1'b1, 1'b1, W'(23));
        settle();
        check(b2a_mail_n, 0);
        i_host_a.rd(1'b1, v);
        check(v, W'(23));
        settle();
        check(b2a_mail_n, 1);
        i_host_a.op(1'b0, 1'b0, 1'b0, 1'b0, '0);
        check(a_dout, W'(18));
        wrap_up();
    end
endmodule : test_dbf_fifo_mailbox
